// *** core/vdt_video_dram_timing.v ***
`timescale 1ns/100ps
`include "vdt_defs.vh"
module vdt_video_dram_timing (
  input wire clk,
  input wire rst_b,
  input wire raw_reset_n,
  input wire [15:0] cpu_addr,
  input wire cpu_rd_wr_n,
  output reg phase_e_ff,
  output reg phase_q_ff,
  output reg clk4_ff,
  output reg clk2_ff,
  output reg synced_reset_n,
  output reg [13:0] scan_addr_ff,
  output reg row_col_select,
  output reg owner_select,
  output reg [6:0] dram_addr_bus,
  output reg ras_n_ff,
  output reg cas_n_ff,
  output reg write_window_ff,
  output reg shifter_load_n,
  output reg bank1_read_en_n,
  output reg bank2_read_en_n,
  output reg bank3_read_en_n,
  output reg bank1_write_en_n,
  output reg bank2_write_en_n,
  output reg bank3_write_en_n,
  output reg bank1_sel_n,
  output reg bank2_sel_n,
  output reg bank3_sel_n,
  output reg unused_bank_code_n
);
  // all derived clocks are registers stepped by one-cycle enables of the 12 MHz clk
  reg [1:0] div3_ff;
  reg en4_ff;
  reg en2_ff;
  reg mux_a_ff;
  reg e_prev_ff;
  wire tick4;
  wire tick2;
  wire tick2b;
  wire e_rise;
  wire [13:0] scan_addr;
  wire [5:0] pseudo_addr;
  wire [1:0] bank_code;
  wire top_quarter;
  wire own_cpu;
  wire [6:0] row_bits;
  wire [6:0] col_bits;
  wire [3:0] sel_n;
  wire rd;
  wire wr_ok;
  wire srl_n;

  // divide by three; 4 MHz enable once per third edge
  always @(posedge clk) begin
    if (!rst_b) begin
      div3_ff <= 2'h0;
    end else if (div3_ff == `VDT_DIV3_LAST) begin
      div3_ff <= 2'h0;
    end else begin
      div3_ff <= div3_ff + 2'h1;
    end
  end
  assign tick4 = (div3_ff == `VDT_DIV3_LAST);

  // 4 MHz clock high two of three cycles and 2 MHz toggle
  always @(posedge clk) begin
    if (!rst_b) begin
      clk4_ff <= 1'b0;
      en4_ff <= 1'b0;
      clk2_ff <= 1'b0;
    end else begin
      en4_ff <= tick4;
      if (tick4) begin
        clk4_ff <= 1'b1;
      end else if (div3_ff == 2'h0 && en4_ff) begin
        clk4_ff <= clk4_ff;
      end else if (div3_ff == 2'h1) begin
        clk4_ff <= 1'b0;
      end
      if (tick4) begin
        clk2_ff <= ~clk2_ff;
      end
    end
  end
  assign tick2 = tick4 & ~clk2_ff;
  // opposite 2 MHz edge, a quarter period after the quadrature step
  assign tick2b = tick4 & clk2_ff;

  // quadrature toggles, main phase samples it a 4 MHz tick later
  always @(posedge clk) begin
    if (!rst_b) begin
      phase_q_ff <= 1'b0;
      phase_e_ff <= 1'b0;
    end else begin
      if (tick2) begin
        phase_q_ff <= ~phase_q_ff;
      end
      if (tick2b) begin
        phase_e_ff <= phase_q_ff;
      end
    end
  end
  // en2_ff unused otherwise; mark 2 MHz edge for reset release
  always @(posedge clk) begin
    if (!rst_b) begin
      en2_ff <= 1'b0;
      e_prev_ff <= 1'b0;
    end else begin
      en2_ff <= tick2b;
      e_prev_ff <= phase_e_ff;
    end
  end
  assign e_rise = phase_e_ff & ~e_prev_ff & en2_ff;

  // synced reset follows raw reset, released on phase rise
  always @(posedge clk) begin
    if (!rst_b || !raw_reset_n) begin
      synced_reset_n <= 1'b0;
    end else if (e_rise) begin
      synced_reset_n <= 1'b1;
    end
  end

  // scan counter at 4 MHz
  vdt_scan_counter u_scan (
    .clk(clk),
    .rst_b(rst_b),
    .cnt_en(tick4),
    .clr_b(synced_reset_n),
    .scan_addr(scan_addr)
  );

  // lookup table on processor high byte
  vdt_bank_table #(
    .BANK_SPLIT(2'h1)
  ) u_table (
    .cpu_addr_hi(cpu_addr[15:8]),
    .pseudo_addr(pseudo_addr),
    .bank_code(bank_code)
  );

  // processor owns the slot only in high phase below top quarter
  assign top_quarter = cpu_addr[15] & cpu_addr[14];
  assign own_cpu = phase_e_ff & ~top_quarter;
  // row and column sources
  assign row_bits = own_cpu ? {pseudo_addr, cpu_addr[0]} : scan_addr[6:0];
  assign col_bits = own_cpu ? cpu_addr[7:1] : scan_addr[13:7];
  // 1-of-4 bank decode
  assign sel_n[0] = ~(bank_code == `VDT_BANK1);
  assign sel_n[1] = ~(bank_code == `VDT_BANK2);
  assign sel_n[2] = ~(bank_code == `VDT_BANK3);
  assign sel_n[3] = ~(bank_code == `VDT_BANK_NONE);
  assign rd = cpu_rd_wr_n & own_cpu;
  assign wr_ok = ~cpu_rd_wr_n & phase_e_ff & write_window_ff
    & ~top_quarter;
  // load pulse in scan slot: quadrature low, window high, row low
  assign srl_n = ~(~phase_q_ff & write_window_ff & ~ras_n_ff & ~own_cpu
    & ~phase_e_ff);

  // select is phase xor through two 12 MHz registers
  always @(posedge clk) begin
    if (!rst_b) begin
      mux_a_ff <= 1'b0;
      row_col_select <= 1'b0;
      write_window_ff <= 1'b0;
      cas_n_ff <= 1'b1;
      ras_n_ff <= 1'b1;
    end else begin
      mux_a_ff <= phase_e_ff ^ phase_q_ff;
      row_col_select <= mux_a_ff;
      // column strobe and window one step behind select
      write_window_ff <= row_col_select;
      cas_n_ff <= ~row_col_select;
      // row strobe falls as select rises, stays low one step past it
      ras_n_ff <= ~(mux_a_ff | row_col_select);
    end
  end

  // registered address bus and enables
  always @(posedge clk) begin
    if (!rst_b) begin
      owner_select <= 1'b1;
      dram_addr_bus <= 7'h00;
      scan_addr_ff <= 14'h0000;
      shifter_load_n <= 1'b1;
      bank1_sel_n <= 1'b1;
      bank2_sel_n <= 1'b1;
      bank3_sel_n <= 1'b1;
      unused_bank_code_n <= 1'b1;
      bank1_read_en_n <= 1'b1;
      bank2_read_en_n <= 1'b1;
      bank3_read_en_n <= 1'b1;
      bank1_write_en_n <= 1'b1;
      bank2_write_en_n <= 1'b1;
      bank3_write_en_n <= 1'b1;
    end else begin
      owner_select <= ~own_cpu; // low selects processor
      // row bits while select low, column while high
      dram_addr_bus <= mux_a_ff ? col_bits : row_bits;
      scan_addr_ff <= scan_addr;
      shifter_load_n <= srl_n;
      bank1_sel_n <= sel_n[0];
      bank2_sel_n <= sel_n[1];
      bank3_sel_n <= sel_n[2];
      unused_bank_code_n <= sel_n[3];
      bank1_read_en_n <= ~(rd & ~sel_n[0]);
      bank2_read_en_n <= ~(rd & ~sel_n[1]);
      bank3_read_en_n <= ~(rd & ~sel_n[2]);
      bank1_write_en_n <= ~(wr_ok & ~sel_n[0]);
      bank2_write_en_n <= ~(wr_ok & ~sel_n[1]);
      bank3_write_en_n <= ~(wr_ok & ~sel_n[2]);
    end
  end
endmodule

// *** include/vdt_defs.vh ***
// Notes on behaviour
// - two 1 MHz phase clocks, quadrature leads
// - 4 MHz toggles to 2 MHz, then quadrature
// - main phase samples quadrature on 2 MHz
// - 16-bit scan counter at 4 MHz, top 14
// - synced reset clears counter, else always counts
// - synchronous cascaded nibbles, carries from below
// - first 16383 loads 16128, second wraps zero
// - top scan bit falling rearms the preload
// - address high byte indexes pseudo/bank table
// - bank code 0,1,2 selects banks; 3 unused
// - top quarter inhibits video ram access
// - read pulses selected bank latch enable low
// - write enable needs write, phase, window
// - owner select processor only in phase, low map
// - phase xor registered twice gives row/col select
// - select low row bits, high column bits
// - row strobe with select high, column one step later
// - shifter load from quadrature, window, row strobe
// - processor row pseudo plus bit 0, column 1-7
// - scan row bits 0-6, column 7-13
// - top quarter cycles scan, data goes nowhere
// - 4 MHz from 12 MHz divided by three
// - synced reset releases on phase clock rise
`ifndef VDT_DEFS_VH
`define VDT_DEFS_VH
`define VDT_DIV3_LAST 2'h2
`define VDT_SCAN_TOP 14'h3fff
`define VDT_SCAN_PRELOAD 14'h3f00
`define VDT_CNT_W 16
`define VDT_NIB 4
`define VDT_BANK1 2'h0
`define VDT_BANK2 2'h1
`define VDT_BANK3 2'h2
`define VDT_BANK_NONE 2'h3
`endif

// *** core/vdt_scan_counter.v ***
`timescale 1ns/100ps
`include "vdt_defs.vh"
module vdt_scan_counter (
  input wire clk,
  input wire rst_b,
  input wire cnt_en,
  input wire clr_b,
  output wire [13:0] scan_addr
);
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg preload_ff;
  reg nxt_preload;
  reg top_bit_ff;
  wire tc_low;
  wire tc_top;
  wire [3:0] n0;
  wire [3:0] n1;
  wire [3:0] n2;
  wire [3:0] n3;
  // nibble increment helper
  function [3:0] inc4;
    input [3:0] v;
    input en;
    begin
      inc4 = en ? v + 4'h1 : v;
    end
  endfunction
  assign scan_addr = cnt_ff[15:2];
  assign tc_low = &cnt_ff[3:0];
  assign tc_top = (cnt_ff[15:2] == `VDT_SCAN_TOP) && (&cnt_ff[1:0]);
  // each nibble counts only on carry from all lower ones
  assign n0 = inc4(cnt_ff[3:0], 1'b1);
  assign n1 = inc4(cnt_ff[7:4], tc_low);
  assign n2 = inc4(cnt_ff[11:8], tc_low & (&cnt_ff[7:4]));
  assign n3 = inc4(cnt_ff[15:12], tc_low & (&cnt_ff[11:4]));
  // next count with shortened frame preload
  always @* begin
    nxt_cnt = {n3, n2, n1, n0};
    nxt_preload = preload_ff;
    if (tc_top && !preload_ff) begin
      nxt_cnt = {`VDT_SCAN_PRELOAD, 2'h0};
      nxt_preload = 1'b1;
    end else if (tc_top) begin
      nxt_cnt = {`VDT_CNT_W{1'b0}};
    end
    if (top_bit_ff && !nxt_cnt[15]) begin
      nxt_preload = 1'b0;
    end
  end
  // counter runs on 4 MHz enables, cleared by synced reset
  always @(posedge clk) begin
    if (!rst_b || !clr_b) begin
      cnt_ff <= {`VDT_CNT_W{1'b0}};
      preload_ff <= 1'b0;
      top_bit_ff <= 1'b0;
    end else if (cnt_en) begin
      cnt_ff <= nxt_cnt;
      preload_ff <= nxt_preload;
      top_bit_ff <= nxt_cnt[15];
    end
  end
endmodule

// *** core/vdt_bank_table.v ***
`timescale 1ns/100ps
`include "vdt_defs.vh"
module vdt_bank_table #(
  parameter [1:0] BANK_SPLIT = 2'h1
) (
  input wire [7:0] cpu_addr_hi,
  output reg [5:0] pseudo_addr,
  output reg [1:0] bank_code
);
  // lookup: high byte maps to pseudo row bits and bank code
  always @* begin
    pseudo_addr = cpu_addr_hi[5:0];
    case (cpu_addr_hi[7:6])
      2'h0: bank_code = `VDT_BANK1;
      2'h1: bank_code = `VDT_BANK2;
      2'h2: bank_code = `VDT_BANK3;
      default: bank_code = `VDT_BANK_NONE;
    endcase
    if (BANK_SPLIT == 2'h0) begin
      bank_code = `VDT_BANK1;
    end
  end
endmodule

// *** verification/vdt_monitor.sv ***
`timescale 1ns/100ps
module vdt_monitor (
  input wire clk,
  input wire rst_b,
  input wire [15:0] cpu_addr,
  input wire cpu_rd_wr_n,
  input wire phase_e_ff,
  input wire phase_q_ff,
  input wire [13:0] scan_addr_ff,
  input wire synced_reset_n,
  input wire row_col_select,
  input wire owner_select,
  input wire shifter_load_n,
  input wire bank1_read_en_n,
  input wire bank2_read_en_n,
  input wire bank3_read_en_n,
  input wire bank1_write_en_n,
  input wire bank2_write_en_n,
  input wire bank3_write_en_n
);
  // decoded views of the enables and the top quarter
  wire top_q = &cpu_addr[15:14];
  wire rd_any = !(bank1_read_en_n && bank2_read_en_n && bank3_read_en_n);
  wire wr_any = !(bank1_write_en_n && bank2_write_en_n && bank3_write_en_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_qhi;
    $rose(phase_q_ff) |-> phase_q_ff[*6] ##1 !phase_q_ff;
  endproperty
  a_qhi: assert property (p_qhi) else $error("q width");
  property p_elag;
    $rose(phase_q_ff) |-> !phase_e_ff[*3] ##1 phase_e_ff;
  endproperty
  a_elag: assert property (p_elag) else $error("e lag");
  property p_scan;
    disable iff (!rst_b || !synced_reset_n)
    $changed(scan_addr_ff) |=> $stable(scan_addr_ff)[*8];
  endproperty
  a_scan: assert property (p_scan) else $error("scan rate");
  property p_inc;
    $changed(scan_addr_ff) && scan_addr_ff != 14'h0 &&
      scan_addr_ff != 14'h3f00 |-> scan_addr_ff == $past(scan_addr_ff) + 14'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("scan step");
  property p_top;
    top_q ##1 top_q |-> owner_select && !rd_any && !wr_any;
  endproperty
  a_top: assert property (p_top) else $error("top quarter");
  property p_own;
    !owner_select |-> $past(phase_e_ff) && !$past(top_q);
  endproperty
  a_own: assert property (p_own) else $error("owner");
  property p_wr;
    wr_any |-> !$past(cpu_rd_wr_n) && $past(phase_e_ff);
  endproperty
  a_wr: assert property (p_wr) else $error("write en");
  property p_rd;
    rd_any |-> $past(cpu_rd_wr_n) && !$past(top_q);
  endproperty
  a_rd: assert property (p_rd) else $error("read en");
  property p_mux;
    $rose(row_col_select) |-> row_col_select[*3] ##1 !row_col_select;
  endproperty
  a_mux: assert property (p_mux) else $error("mux");
  property p_load;
    $fell(shifter_load_n) |-> ##12 $fell(shifter_load_n);
  endproperty
  a_load: assert property (p_load) else $error("load");
  c_own: cover property ($fell(owner_select));
  c_wr: cover property (wr_any);
  c_rd: cover property (rd_any);
endmodule
bind vdt_video_dram_timing vdt_monitor u_mon (.clk, .rst_b, .cpu_addr,
  .cpu_rd_wr_n, .phase_e_ff, .phase_q_ff, .scan_addr_ff, .synced_reset_n,
  .row_col_select,
  .owner_select, .shifter_load_n, .bank1_read_en_n, .bank2_read_en_n,
  .bank3_read_en_n, .bank1_write_en_n, .bank2_write_en_n,
  .bank3_write_en_n);

// *** verification/vdt_cpu_model.sv ***
`timescale 1ns/100ps
module vdt_cpu_model (
  input wire clk,
  input wire phase_e_ff,
  input wire [15:0] req_addr,
  input wire req_rd,
  output reg [15:0] cpu_addr,
  output reg cpu_rd_wr_n
);
  initial begin
    cpu_addr = 16'h0000;
    cpu_rd_wr_n = 1'b1;
  end
  // a new cycle starts only while e is low, held through e high
  always @(negedge clk) begin
    if (!phase_e_ff) begin
      cpu_addr <= req_addr;
      cpu_rd_wr_n <= req_rd;
    end
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg raw_reset_n = 1'b0;
  reg [15:0] req_addr = 16'h0000;
  reg req_rd = 1'b1;
  wire [15:0] cpu_addr;
  wire cpu_rd_wr_n, phase_e_ff, synced_reset_n, row_col_select, owner_select;
  wire [13:0] scan_addr_ff;
  wire [6:0] dram_addr_bus;
  wire bank1_read_en_n, bank2_read_en_n, bank3_read_en_n;
  wire bank1_write_en_n, bank2_write_en_n, bank3_write_en_n;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer i, k;
  reg [2:0] rd_seen, wr_seen, mask;
  reg own_seen;
  // rows: address, read flag, pad, expected bank (3 = none)
  reg [19:0] rows [0:5];
  vdt_cpu_model u_cpu (.clk, .phase_e_ff, .req_addr, .req_rd, .cpu_addr,
    .cpu_rd_wr_n);
  vdt_video_dram_timing u_dut (.clk, .rst_b, .raw_reset_n, .cpu_addr,
    .cpu_rd_wr_n, .phase_e_ff, .phase_q_ff(), .clk4_ff(), .clk2_ff(),
    .synced_reset_n, .scan_addr_ff, .row_col_select, .owner_select,
    .dram_addr_bus, .ras_n_ff(), .cas_n_ff(), .write_window_ff(),
    .shifter_load_n(), .bank1_read_en_n, .bank2_read_en_n, .bank3_read_en_n,
    .bank1_write_en_n, .bank2_write_en_n, .bank3_write_en_n,
    .bank1_sel_n(), .bank2_sel_n(), .bank3_sel_n(), .unused_bank_code_n());
  initial forever #12.5 clk = ~clk;
  task check(input string nm, input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      if (n_mismatch == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // bounded wait for the processor slot carrying the request
  task wait_e;
    begin
      k = 0;
      while (!(phase_e_ff === 1'b1 && cpu_addr === req_addr) && k < 40) begin
        @(negedge clk);
        k = k + 1;
      end
      if (!(phase_e_ff === 1'b1 && cpu_addr === req_addr)) begin
        n_mismatch = n_mismatch + 1;
        print_verdict;
      end
    end
  endtask
  // main sequence
  initial begin
    rows[0] = {16'h1234, 4'h8};
    rows[1] = {16'h5678, 4'h1};
    rows[2] = {16'hc000, 4'h7};
    rows[3] = {16'h9abc, 4'h6};
    rows[4] = {16'h8001, 4'h2};
    rows[5] = {16'h40fe, 4'h5};
    repeat (5) @(negedge clk);
    check("owner", {15'h0, owner_select}, 16'h1);
    check("scan", {2'h0, scan_addr_ff}, 16'h0);
    rst_b = 1'b1;
    raw_reset_n = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge clk);
      req_addr = rows[i][19:4];
      req_rd = rows[i][3];
      wait_e;
      rd_seen = 3'h0;
      wr_seen = 3'h0;
      own_seen = 1'b0;
      repeat (12) begin
        @(negedge clk);
        rd_seen = rd_seen |
          ~{bank3_read_en_n, bank2_read_en_n, bank1_read_en_n};
        wr_seen = wr_seen |
          ~{bank3_write_en_n, bank2_write_en_n, bank1_write_en_n};
        own_seen = own_seen | !owner_select;
        if (!owner_select && row_col_select)
          check("col", {9'h0, dram_addr_bus}, {9'h0, req_addr[7:1]});
      end
      mask = (rows[i][1:0] == 2'h3) ? 3'h0 : 3'h1 << rows[i][1:0];
      check("rd", {13'h0, rd_seen}, {13'h0, req_rd ? mask : 3'h0});
      check("wr", {13'h0, wr_seen}, {13'h0, req_rd ? 3'h0 : mask});
      check("own", {15'h0, own_seen}, {15'h0, mask != 3'h0});
    end
    raw_reset_n = 1'b0;
    repeat (3) @(negedge clk);
    check("sync", {15'h0, synced_reset_n}, 16'h0);
    check("scan_clr", {2'h0, scan_addr_ff}, 16'h0);
    raw_reset_n = 1'b1;
    k = 0;
    while (synced_reset_n !== 1'b1 && k < 30) begin
      @(negedge clk);
      k = k + 1;
    end
    check("sync_rel", {15'h0, synced_reset_n}, 16'h1);
    check("e_at_sync", {15'h0, phase_e_ff}, 16'h1);
    repeat (60) @(negedge clk);
    check("scan_rate", {15'h0, scan_addr_ff >= 14'h4 &&
      scan_addr_ff <= 14'h6}, 16'h1);
    print_verdict;
  end
endmodule
